// File: pkg/asram_map.vh
`ifndef ASRAM_MAP_VH
`define ASRAM_MAP_VH
// data and address widths
`define ASRAM_DW 8
`define ASRAM_AW 18
// timing in ns at an 8 ns clock
`define ASRAM_CLK_NS 8
`define ASRAM_T_SETUP_NS 0
`define ASRAM_T_PWE_NS 35
`define ASRAM_T_WR_FLOAT_NS 18
`define ASRAM_T_DSETUP_NS 25
`define ASRAM_T_RC_NS 45
`define ASRAM_T_HZ_NS 18
// derived cycle counts, least times rounded up
`define ASRAM_CYC(t) ((((t) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS) < 1 ? 1 : \
    (((t) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS))
`define ASRAM_WR_CYC `ASRAM_CYC(`ASRAM_T_WR_FLOAT_NS + `ASRAM_T_DSETUP_NS)
`define ASRAM_PWE_CYC `ASRAM_CYC(`ASRAM_T_PWE_NS)
`define ASRAM_RD_CYC `ASRAM_CYC(`ASRAM_T_RC_NS)
`define ASRAM_HZ_CYC `ASRAM_CYC(`ASRAM_T_HZ_NS)
`define ASRAM_CNT_W 4
// synchroniser stages on the returning data bus
`define ASRAM_SYNC_CYC 2
`endif

// File: design/asram_pin_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for the returning data bus
module asram_pin_sync
(
    // clock and reset
    input  wire       clk_in,
    input  wire       nrst_in,
    // pin side
    input  wire [7:0] pin_in,
    // synchronised side
    output wire [7:0] sync_out
);
    reg [7:0] meta_q;
    reg [7:0] sync_q;

    // first stage feeds only the second
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: design/asram_ctrl.v
`timescale 1ns/1ps
`include "asram_map.vh"
// Overview of operation
// - assert all three qualifiers to start write
// - data setup and hold against ending edge
// - never drive data while device drives
// - always drive selects to valid levels
// - strobe width at least float plus setup
module asram_ctrl
(
    // clock and reset
    input  wire                  clk_in,
    input  wire                  nrst_in,
    // user request
    input  wire                  req_valid_in,
    input  wire                  req_write_in,
    input  wire [`ASRAM_AW-1:0]  req_addr_in,
    input  wire [`ASRAM_DW-1:0]  req_wdata_in,
    output wire                  req_ready_out,
    // user answer
    output reg                   rsp_valid_out,
    output reg  [`ASRAM_DW-1:0]  rsp_rdata_out,
    // memory pins
    output reg                   select_active_low_out,
    output reg                   select_active_high_out,
    output reg                   write_strobe_n_out,
    output reg                   output_enable_n_out,
    output reg  [`ASRAM_AW-1:0]  addr_out,
    output reg  [`ASRAM_DW-1:0]  data_out,
    output reg                   data_oe_out,
    input  wire [`ASRAM_DW-1:0]  data_in
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_WRITE = 3'h1;
    localparam [2:0] ST_WEND  = 3'h2;
    localparam [2:0] ST_READ  = 3'h3;
    localparam [2:0] ST_RSYNC = 3'h4;
    localparam [2:0] ST_FLOAT = 3'h5;
    // counts worked out at full width, then cut to the counter on purpose
    localparam integer WR_CYC_I   = `ASRAM_WR_CYC > `ASRAM_PWE_CYC ?
        `ASRAM_WR_CYC : `ASRAM_PWE_CYC;
    localparam integer RD_CYC_I   = `ASRAM_RD_CYC;
    localparam integer HZ_CYC_I   = `ASRAM_HZ_CYC;
    localparam integer SYNC_CYC_I = `ASRAM_SYNC_CYC;
    localparam [`ASRAM_CNT_W-1:0] WR_CYC   = WR_CYC_I[`ASRAM_CNT_W-1:0];
    localparam [`ASRAM_CNT_W-1:0] RD_CYC   = RD_CYC_I[`ASRAM_CNT_W-1:0];
    localparam [`ASRAM_CNT_W-1:0] HZ_CYC   = HZ_CYC_I[`ASRAM_CNT_W-1:0];
    localparam [`ASRAM_CNT_W-1:0] SYNC_CYC = SYNC_CYC_I[`ASRAM_CNT_W-1:0];

    // sequencer state and the shared down-counter
    reg  [2:0]              state_q;
    reg  [`ASRAM_CNT_W-1:0] cnt_q;
    wire [`ASRAM_DW-1:0]    rd_sync;
    wire                    take_wr;
    wire                    take_rd;

    // count expiry shared by every timed state
    function cnt_done;
        input [`ASRAM_CNT_W-1:0] c;
        begin
            cnt_done = (c == {`ASRAM_CNT_W{1'b0}});
        end
    endfunction

    // one step down, used to load and to run every timed count
    function [`ASRAM_CNT_W-1:0] cnt_dec;
        input [`ASRAM_CNT_W-1:0] c;
        begin
            cnt_dec = c - {{(`ASRAM_CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    asram_pin_sync u_sync
    (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .pin_in   (data_in),
        .sync_out (rd_sync)
    );

    assign req_ready_out = (state_q == ST_IDLE);

    // a request is taken only while idle; a busy block leaves it waiting
    assign take_wr = req_valid_in && req_ready_out && req_write_in;
    assign take_rd = req_valid_in && req_ready_out && !req_write_in;

    // pin sequencer; selects always driven to full levels
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q                <= ST_IDLE;
            cnt_q                  <= {`ASRAM_CNT_W{1'b0}};
            select_active_low_out  <= 1'b1;
            select_active_high_out <= 1'b0;
            write_strobe_n_out     <= 1'b1;
            output_enable_n_out    <= 1'b1;
            addr_out               <= {`ASRAM_AW{1'b0}};
        end
        else
        begin
            case (state_q)
                // idle: wait for a request, then select and start the cycle
                ST_IDLE:
                begin
                    if (take_wr || take_rd)
                    begin
                        addr_out               <= req_addr_in;
                        select_active_low_out  <= 1'b0;
                        select_active_high_out <= 1'b1;
                    end
                    if (take_wr)
                    begin
                        // oe high keeps the device quiet before we drive
                        output_enable_n_out <= 1'b1;
                        write_strobe_n_out  <= 1'b0;
                        cnt_q               <= cnt_dec(WR_CYC);
                        state_q             <= ST_WRITE;
                    end
                    else if (take_rd)
                    begin
                        output_enable_n_out <= 1'b0;
                        write_strobe_n_out  <= 1'b1;
                        cnt_q               <= cnt_dec(RD_CYC);
                        state_q             <= ST_READ;
                    end
                end
                // write: strobe held low for the full pulse width
                ST_WRITE:
                begin
                    if (cnt_done(cnt_q))
                    begin
                        // strobe alone ends the write; data held past it
                        write_strobe_n_out <= 1'b1;
                        state_q            <= ST_WEND;
                    end
                    else
                        cnt_q <= cnt_dec(cnt_q);
                end
                // write end: selects drop one cycle after the strobe edge
                ST_WEND:
                begin
                    select_active_low_out  <= 1'b1;
                    select_active_high_out <= 1'b0;
                    state_q                <= ST_IDLE;
                end
                // read: address and enables held for the read cycle time
                ST_READ:
                begin
                    if (cnt_done(cnt_q))
                    begin
                        cnt_q   <= cnt_dec(SYNC_CYC);
                        state_q <= ST_RSYNC;
                    end
                    else
                        cnt_q <= cnt_dec(cnt_q);
                end
                ST_RSYNC:
                begin
                    // wait out the synchroniser latency, pins held steady
                    if (cnt_done(cnt_q))
                    begin
                        output_enable_n_out    <= 1'b1;
                        select_active_low_out  <= 1'b1;
                        select_active_high_out <= 1'b0;
                        cnt_q                  <= cnt_dec(HZ_CYC);
                        state_q                <= ST_FLOAT;
                    end
                    else
                        cnt_q <= cnt_dec(cnt_q);
                end
                ST_FLOAT:
                begin
                    // bus turnaround before we may drive again
                    if (cnt_done(cnt_q))
                        state_q <= ST_IDLE;
                    else
                        cnt_q <= cnt_dec(cnt_q);
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // write data drive: from the take until one cycle past the ending edge
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            data_out    <= {`ASRAM_DW{1'b0}};
            data_oe_out <= 1'b0;
        end
        else if (take_wr)
        begin
            data_out    <= req_wdata_in;
            data_oe_out <= 1'b1;
        end
        else if (state_q == ST_WEND)
            data_oe_out <= 1'b0;
    end

    // read answer: one-cycle pulse, byte kept until the next read
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {`ASRAM_DW{1'b0}};
        end
        else if (state_q == ST_RSYNC && cnt_done(cnt_q))
        begin
            rsp_valid_out <= 1'b1;
            rsp_rdata_out <= rd_sync;
        end
        else
            rsp_valid_out <= 1'b0;
    end
endmodule

// File: test/asram_ctrl_assertions.sv
`timescale 1ns/1ps
module asram_ctrl_assertions
(
    // watched ports
    input wire        clk_in,
    input wire        nrst_in,
    input wire        req_valid_in,
    input wire        req_write_in,
    input wire        req_ready_out,
    input wire        rsp_valid_out,
    input wire        select_active_low_out,
    input wire        select_active_high_out,
    input wire        write_strobe_n_out,
    input wire        output_enable_n_out,
    input wire [17:0] addr_out,
    input wire [7:0]  data_out,
    input wire        data_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // both parties must never drive the data pins at once
    no_bus_fight_a: assert property (!(data_oe_out && !output_enable_n_out))
        else $error("data driven while output enable low");
    sel_pair_a: assert property (select_active_low_out == !select_active_high_out)
        else $error("selects out of step");
    strobe_qual_a: assert property (!write_strobe_n_out |->
        !select_active_low_out && select_active_high_out && data_oe_out)
        else $error("strobe low without full qualification");
    strobe_width_a: assert property ($fell(write_strobe_n_out) |->
        !write_strobe_n_out [*6] ##1 write_strobe_n_out) else $error("strobe width wrong");
    data_setup_a: assert property ($fell(write_strobe_n_out) |=>
        ($stable(data_out) && $stable(addr_out)) [*6]) else $error("write data moved");
    write_end_a: assert property ($rose(write_strobe_n_out) |-> data_oe_out ##1
        (select_active_low_out && !data_oe_out)) else $error("write end order wrong");
    read_answer_a: assert property (req_valid_in && req_ready_out && !req_write_in
        |-> ##9 rsp_valid_out) else $error("read answer late");
    read_qual_a: assert property (!output_enable_n_out |->
        !select_active_low_out && write_strobe_n_out) else $error("enable low unselected");
endmodule
bind asram_ctrl asram_ctrl_assertions u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .select_active_low_out(select_active_low_out),
    .select_active_high_out(select_active_high_out), .write_strobe_n_out(write_strobe_n_out),
    .output_enable_n_out(output_enable_n_out), .addr_out(addr_out), .data_out(data_out),
    .data_oe_out(data_oe_out));

// File: test/asram_dev_model.sv
`timescale 1ns/1ps
module asram_dev_model
(
    // memory pins
    input  wire        sel_n_in,
    input  wire        sel_in,
    input  wire        we_n_in,
    input  wire        oe_n_in,
    input  wire [17:0] addr_in,
    input  wire [7:0]  bus_in,
    // device drive
    output wire [7:0]  rdata_out,
    output wire        drive_out
);
    reg  [7:0] mem [0:262143];
    wire       chosen = !sel_n_in && sel_in;
    wire       writing = chosen && !we_n_in;
    // drives only in read mode, floats on write, disable or deselect
    assign drive_out = chosen && we_n_in && !oe_n_in;
    assign rdata_out = mem[addr_in];
    // first qualifier to drop ends the write and latches data
    always @(negedge writing)
        mem[addr_in] = bus_in;
endmodule

// File: test/asram_ctrl_bench.sv
`timescale 1ns/1ps
module asram_ctrl_bench;
    reg         clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg         req_valid_in = 1'b0;
    reg         req_write_in = 1'b0;
    reg  [17:0] req_addr_in = 18'h0;
    reg  [7:0]  req_wdata_in = 8'h0;
    wire        req_ready_out, rsp_valid_out, sel_n, sel, we_n, oe_n, data_oe, drive;
    wire [17:0] addr;
    wire [7:0]  rsp_rdata_out, data_out, rdata, bus;
    integer     failures = 0, n_compared = 0, cyc = 0, i, lw;
    always #4 clk_in = ~clk_in;
    // undriven bus shows a changing pattern, never a stale byte
    assign bus = drive ? rdata : data_oe ? data_out : cyc[7:0] ^ 8'h5a;
    asram_ctrl dut (.clk_in(clk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .select_active_low_out(sel_n),
        .select_active_high_out(sel), .write_strobe_n_out(we_n),
        .output_enable_n_out(oe_n), .addr_out(addr), .data_out(data_out),
        .data_oe_out(data_oe), .data_in(bus));
    asram_dev_model u_mem (.sel_n_in(sel_n), .sel_in(sel), .we_n_in(we_n), .oe_n_in(oe_n),
        .addr_in(addr), .bus_in(bus), .rdata_out(rdata), .drive_out(drive));
    task end_sim;
        begin
            if (failures == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task check(input [79:0] what, input [17:0] got, input [17:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // one request, then count strobe-low cycles until answer or idle
    task req(input w, input [17:0] a, input [7:0] d);
        begin
            @(negedge clk_in);
            for (i = 0; i < 30 && req_ready_out !== 1'b1; i = i + 1)
                @(negedge clk_in);
            req_valid_in = 1'b1;
            req_write_in = w;
            req_addr_in = a;
            req_wdata_in = d;
            @(negedge clk_in);
            req_valid_in = 1'b0;
            lw = 0;
            for (i = 0; i < 30 && req_ready_out !== 1'b1 && rsp_valid_out !== 1'b1; i = i + 1)
            begin
                lw = lw + (we_n === 1'b0);
                @(negedge clk_in);
            end
        end
    endtask
    task wr(input [17:0] a, input [7:0] d);
        begin
            req(1'b1, a, d);
            check("strobe", lw, 18'd6);
        end
    endtask
    task rd(input [17:0] a, input [7:0] e);
        begin
            req(1'b0, a, 8'h00);
            check("rdata", rsp_rdata_out, e);
        end
    endtask
    // back-to-back writes at both ends of the array, then read-back
    task t_boundary;
        begin
            wr(18'h00000, 8'ha5);
            wr(18'h3ffff, 8'h5a);
            rd(18'h3ffff, 8'h5a);
            rd(18'h00000, 8'ha5);
        end
    endtask
    // contents survive idle deselect and other traffic
    task t_retain;
        begin
            wr(18'h12345, 8'hc3);
            rd(18'h00000, 8'ha5);
            repeat (20) @(negedge clk_in);
            check("idle_sel", {sel_n, sel, data_oe}, 18'h4);
            rd(18'h12345, 8'hc3);
        end
    endtask
    // reset in mid-write: pins deselected at once, then a clean write and read
    task t_reset;
        begin
            @(negedge clk_in);
            while (req_ready_out !== 1'b1)
                @(negedge clk_in);
            req_valid_in = 1'b1;
            req_write_in = 1'b1;
            req_addr_in = 18'h00100;
            req_wdata_in = 8'h3c;
            @(negedge clk_in);
            req_valid_in = 1'b0;
            repeat (2) @(negedge clk_in);
            nrst_in = 1'b0;
            @(negedge clk_in);
            check("rst_pins", {sel_n, sel, we_n, oe_n, data_oe, req_ready_out}, 18'h2d);
            nrst_in = 1'b1;
            wr(18'h00100, 8'hc3);
            rd(18'h00100, 8'hc3);
        end
    endtask
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            failures = failures + 1;
            end_sim;
        end
    end
    initial
    begin
        repeat (16) @(negedge clk_in);
        nrst_in = 1'b1;
        t_boundary;
        t_retain;
        t_reset;
        end_sim;
    end
endmodule
